// ===== verilog/mds_params.svh
// Widths, reset values and slice-wide constants of the multiply-accumulate slice.
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH
`define MDS_OPW       16
`define MDS_BYTEW     8
`define MDS_ACCW      32
`define MDS_PARTW     18
`define MDS_OP_RST    16'h0000
`define MDS_PART_RST  18'h00000
`define MDS_PROD_RST  32'h0000_0000
`define MDS_HI_LSB    16
`endif

// ===== verilog/mds_pkg.sv
// Configuration types of the multiply-accumulate slice.
package mds_pkg;
  // Operand that meets the adder: the raw first/second operand or the product.
  typedef enum logic {MDS_OP_DIRECT, MDS_OP_PRODUCT} mds_op_src_t;
  // Other adder input: the accumulator itself or the third/fourth operand.
  typedef enum logic {MDS_ADD_ACC, MDS_ADD_OPERAND} mds_addend_t;
  // What the result output shows: the product or the adder/accumulator halves.
  typedef enum logic {MDS_OUT_PRODUCT, MDS_OUT_ADDER} mds_out_sel_t;
  // Where the lower adder takes its carry/borrow from.
  typedef enum logic [1:0] {MDS_CIN_NONE, MDS_CIN_FABRIC, MDS_CIN_CHAIN} mds_cin_src_t;
endpackage

// ===== verilog/mds_opreg.sv
// Bypassable operand register with hold and synchronous clear.
`timescale 1ns/1ps
module mds_opreg #(
  parameter int W          = 16,
  parameter bit REGISTERED = 1'b1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         cycle_permit_in,
  input  wire logic         freeze_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] held;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      held <= '0;
    end else if (cycle_permit_in) begin
      if (clear_in) begin
        held <= '0;
      end else if (!freeze_in) begin
        held <= d_in;
      end
    end
  end

  assign q_out = REGISTERED ? held : d_in;
endmodule

// ===== verilog/mds_acc_half.sv
// One 16-bit adder/subtracter with its accumulator register.
`timescale 1ns/1ps
module mds_acc_half #(
  parameter int W          = 16,
  parameter bit FROM_ACC   = 1'b1,
  parameter bit REGISTERED = 1'b1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         cycle_permit_in,
  input  wire logic         freeze_in,
  input  wire logic         clear_in,
  input  wire logic         preset_sel_in,
  input  wire logic         minus_sel_in,
  input  wire logic [W-1:0] addend_in,
  input  wire logic [W-1:0] operand_in,
  input  wire logic [W-1:0] preset_in,
  input  wire logic         carry_in,
  output logic      [W-1:0] result_out,
  output logic              carry_out,
  output logic              sign_out
);
  logic [W-1:0] acc;
  logic [W-1:0] lhs;
  logic [W-1:0] rhs;
  logic [W:0]   sum;
  logic [W-1:0] next_acc;

  assign lhs = FROM_ACC ? acc : addend_in;
  assign rhs = minus_sel_in ? ~operand_in : operand_in;
  // Borrow is the inverted carry, so a chain of subtracters stays consistent.
  assign sum = {1'b0, lhs} + {1'b0, rhs} + {{W{1'b0}}, carry_in ^ minus_sel_in};
  assign carry_out = sum[W] ^ minus_sel_in;
  assign sign_out = lhs[W-1] ^ rhs[W-1] ^ sum[W];
  assign next_acc = preset_sel_in ? preset_in : sum[W-1:0];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc <= '0;
    end else if (cycle_permit_in) begin
      if (clear_in) begin
        acc <= '0;
      end else if (!freeze_in) begin
        acc <= next_acc;
      end
    end
  end

  assign result_out = REGISTERED ? acc : next_acc;
endmodule

// ===== verilog/mds_slice.sv
// Multiply-accumulate slice: operand registers, multiplier and two accumulator halves.
//
// Overview of operation
// - One clock drives every register of the slice.
// - Clock enable high lets all registers advance; low freezes them all.
// - First and second operands are registered and feed multiplier or adder.
// - Third and fourth operands are registered and feed only the adder.
// - Each operand register has its own hold: low updates, high keeps.
// - Upper clear zeroes first and third operands and upper pipeline registers.
// - Lower clear zeroes second, fourth operands, lower pipeline and product registers.
// - Output is full 32-bit result, or two 16-bit halves in dual mode.
// - Each accumulator half has its own hold: low updates, high keeps.
// - Each accumulator half has its own clear, high clears that half.
// - Load select low accumulates adder result; high loads the third operand.
// - Each half has an add/subtract select: low adds, high subtracts.
// - Carry/borrow chains from the previous slice and on to the next.
// - Carry/borrow comes from the lower fabric tile and goes to the higher.
// - Sign extension passes from the previous slice to the next one.
// - Supports multiply, add/subtract, accumulate and MAC in both widths.
// - Unconnected operands read zero; unconnected controls take their inactive value, except clock enable, which defaults high.
// - Input, pipeline and output registers are each bypassable.
`timescale 1ns/1ps
`include "mds_params.svh"
module mds_slice import mds_pkg::*; #(
  parameter bit           DUAL_MUL      = 1'b0,
  parameter bit           SIGNED_ONE    = 1'b0,
  parameter bit           SIGNED_TWO    = 1'b0,
  parameter bit           ONE_REG       = 1'b1,
  parameter bit           TWO_REG       = 1'b1,
  parameter bit           HIGH_REG      = 1'b1,
  parameter bit           LOW_REG       = 1'b1,
  parameter bit           PIPE_REG      = 1'b1,
  parameter bit           PROD_REG      = 1'b1,
  parameter bit           ACC_REG       = 1'b1,
  parameter bit           WIDE_ADD      = 1'b1,
  parameter mds_op_src_t  UPPER_OP      = MDS_OP_PRODUCT,
  parameter mds_op_src_t  LOWER_OP      = MDS_OP_PRODUCT,
  parameter mds_addend_t  UPPER_ADDEND  = MDS_ADD_ACC,
  parameter mds_addend_t  LOWER_ADDEND  = MDS_ADD_ACC,
  parameter mds_out_sel_t UPPER_OUT     = MDS_OUT_ADDER,
  parameter mds_out_sel_t LOWER_OUT     = MDS_OUT_ADDER,
  parameter mds_cin_src_t CARRY_SRC     = MDS_CIN_NONE,
  parameter bit           SIGN_PASS     = 1'b0
) (
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input       logic                 cycle_permit_in         = 1'b1,
  input       logic [`MDS_OPW-1:0]  operand_one_in          = `MDS_OP_RST,
  input       logic [`MDS_OPW-1:0]  operand_two_in          = `MDS_OP_RST,
  input       logic [`MDS_OPW-1:0]  addend_high_in          = `MDS_OP_RST,
  input       logic [`MDS_OPW-1:0]  addend_low_in           = `MDS_OP_RST,
  input       logic                 operand_one_freeze_in   = 1'b0,
  input       logic                 operand_two_freeze_in   = 1'b0,
  input       logic                 addend_high_freeze_in   = 1'b0,
  input       logic                 addend_low_freeze_in    = 1'b0,
  input       logic                 upper_input_clear_in    = 1'b0,
  input       logic                 lower_input_clear_in    = 1'b0,
  input       logic                 upper_acc_freeze_in     = 1'b0,
  input       logic                 upper_acc_clear_in      = 1'b0,
  input       logic                 upper_acc_preset_sel_in = 1'b0,
  input       logic                 upper_acc_minus_sel_in  = 1'b0,
  input       logic                 lower_acc_freeze_in     = 1'b0,
  input       logic                 lower_acc_clear_in      = 1'b0,
  input       logic                 lower_acc_preset_sel_in = 1'b0,
  input       logic                 lower_acc_minus_sel_in  = 1'b0,
  input       logic                 chain_carry_in          = 1'b0,
  input       logic                 fabric_carry_in         = 1'b0,
  input       logic                 sign_chain_in           = 1'b0,
  output logic [`MDS_ACCW-1:0]      result_out,
  output logic                      chain_carry_out,
  output logic                      fabric_carry_out,
  output logic                      sign_chain_out
);
  localparam int OW = `MDS_OPW;
  localparam int BW = `MDS_BYTEW;
  localparam int PW = `MDS_PARTW;
  localparam int RW = `MDS_ACCW;

  logic [OW-1:0] one_q;
  logic [OW-1:0] two_q;
  logic [OW-1:0] high_q;
  logic [OW-1:0] low_q;

  // Operand registers: first and third answer to the upper clear,
  // second and fourth to the lower clear.
  mds_opreg #(.W(OW), .REGISTERED(ONE_REG)) u_one (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .cycle_permit_in (cycle_permit_in),
    .freeze_in       (operand_one_freeze_in),
    .clear_in        (upper_input_clear_in),
    .d_in            (operand_one_in),
    .q_out           (one_q)
  );

  mds_opreg #(.W(OW), .REGISTERED(TWO_REG)) u_two (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .cycle_permit_in (cycle_permit_in),
    .freeze_in       (operand_two_freeze_in),
    .clear_in        (lower_input_clear_in),
    .d_in            (operand_two_in),
    .q_out           (two_q)
  );

  mds_opreg #(.W(OW), .REGISTERED(HIGH_REG)) u_high (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .cycle_permit_in (cycle_permit_in),
    .freeze_in       (addend_high_freeze_in),
    .clear_in        (upper_input_clear_in),
    .d_in            (addend_high_in),
    .q_out           (high_q)
  );

  mds_opreg #(.W(OW), .REGISTERED(LOW_REG)) u_low (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .cycle_permit_in (cycle_permit_in),
    .freeze_in       (addend_low_freeze_in),
    .clear_in        (lower_input_clear_in),
    .d_in            (addend_low_in),
    .q_out           (low_q)
  );

  // Byte-wise partial products. Each byte is widened by one extension bit;
  // in a 16x16 product only the high bytes carry a sign, in dual mode all do.
  function automatic logic [PW-1:0] mul9(input logic [BW:0] a, input logic [BW:0] b);
    logic signed [PW-1:0] p;
    p = $signed(a) * $signed(b);
    return p;
  endfunction

  logic          one_hi_ext;
  logic          one_lo_ext;
  logic          two_hi_ext;
  logic          two_lo_ext;
  logic [PW-1:0] part_hh;
  logic [PW-1:0] part_hl;
  logic [PW-1:0] part_lh;
  logic [PW-1:0] part_ll;

  assign one_hi_ext = SIGNED_ONE & one_q[OW-1];
  assign two_hi_ext = SIGNED_TWO & two_q[OW-1];
  assign one_lo_ext = DUAL_MUL & SIGNED_ONE & one_q[BW-1];
  assign two_lo_ext = DUAL_MUL & SIGNED_TWO & two_q[BW-1];

  assign part_hh = mul9({one_hi_ext, one_q[OW-1:BW]}, {two_hi_ext, two_q[OW-1:BW]});
  assign part_hl = mul9({one_hi_ext, one_q[OW-1:BW]}, {two_lo_ext, two_q[BW-1:0]});
  assign part_lh = mul9({one_lo_ext, one_q[BW-1:0]}, {two_hi_ext, two_q[OW-1:BW]});
  assign part_ll = mul9({one_lo_ext, one_q[BW-1:0]}, {two_lo_ext, two_q[BW-1:0]});

  // Intermediate pipeline between the partial products and the final sum.
  logic [PW-1:0] pipe_hh;
  logic [PW-1:0] pipe_hl;
  logic [PW-1:0] pipe_lh;
  logic [PW-1:0] pipe_ll;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pipe_hh <= `MDS_PART_RST;
      pipe_hl <= `MDS_PART_RST;
    end else if (cycle_permit_in) begin
      if (upper_input_clear_in) begin
        pipe_hh <= `MDS_PART_RST;
        pipe_hl <= `MDS_PART_RST;
      end else begin
        pipe_hh <= part_hh;
        pipe_hl <= part_hl;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pipe_lh <= `MDS_PART_RST;
      pipe_ll <= `MDS_PART_RST;
    end else if (cycle_permit_in) begin
      if (lower_input_clear_in) begin
        pipe_lh <= `MDS_PART_RST;
        pipe_ll <= `MDS_PART_RST;
      end else begin
        pipe_lh <= part_lh;
        pipe_ll <= part_ll;
      end
    end
  end

  logic [PW-1:0] use_hh;
  logic [PW-1:0] use_hl;
  logic [PW-1:0] use_lh;
  logic [PW-1:0] use_ll;

  assign use_hh = PIPE_REG ? pipe_hh : part_hh;
  assign use_hl = PIPE_REG ? pipe_hl : part_hl;
  assign use_lh = PIPE_REG ? pipe_lh : part_lh;
  assign use_ll = PIPE_REG ? pipe_ll : part_ll;

  // Final product: one 32-bit sum, or two independent 16-bit products.
  logic [RW-1:0] prod_wide;
  logic [RW-1:0] prod_now;
  logic [RW-1:0] prod_reg;
  logic [RW-1:0] product;

  assign prod_wide = {use_hh[OW-1:0], 16'h0000}
                   + {{6{use_hl[PW-1]}}, use_hl, 8'h00}
                   + {{6{use_lh[PW-1]}}, use_lh, 8'h00}
                   + {{14{use_ll[PW-1]}}, use_ll};
  assign prod_now = DUAL_MUL ? {use_hh[OW-1:0], use_ll[OW-1:0]} : prod_wide;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prod_reg <= `MDS_PROD_RST;
    end else if (cycle_permit_in) begin
      if (lower_input_clear_in) begin
        prod_reg <= `MDS_PROD_RST;
      end else begin
        prod_reg <= prod_now;
      end
    end
  end

  assign product = PROD_REG ? prod_reg : prod_now;

  // Adder inputs for both halves.
  logic [OW-1:0] upper_operand;
  logic [OW-1:0] lower_operand;
  logic          lower_cin;
  logic          upper_cin;
  logic          lower_cout;
  logic          upper_cout;
  logic          upper_sign;
  logic          lower_sign;
  logic [OW-1:0] upper_res;
  logic [OW-1:0] lower_res;

  always_comb begin
    unique case (UPPER_OP)
      MDS_OP_PRODUCT: upper_operand = product[RW-1:`MDS_HI_LSB];
      MDS_OP_DIRECT:  upper_operand = one_q;
    endcase
  end

  always_comb begin
    unique case (LOWER_OP)
      MDS_OP_PRODUCT: lower_operand = product[OW-1:0];
      MDS_OP_DIRECT:  lower_operand = two_q;
    endcase
  end

  always_comb begin
    unique case (CARRY_SRC)
      MDS_CIN_FABRIC: lower_cin = fabric_carry_in;
      MDS_CIN_CHAIN:  lower_cin = chain_carry_in;
      default:        lower_cin = 1'b0;
    endcase
  end

  // A 32-bit add carries from the lower half into the upper one.
  assign upper_cin = WIDE_ADD ? lower_cout : 1'b0;

  mds_acc_half #(
    .W          (OW),
    .FROM_ACC   (UPPER_ADDEND == MDS_ADD_ACC),
    .REGISTERED (ACC_REG)
  ) u_upper (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .cycle_permit_in (cycle_permit_in),
    .freeze_in       (upper_acc_freeze_in),
    .clear_in        (upper_acc_clear_in),
    .preset_sel_in   (upper_acc_preset_sel_in),
    .minus_sel_in    (upper_acc_minus_sel_in),
    .addend_in       (high_q),
    .operand_in      (upper_operand),
    .preset_in       (high_q),
    .carry_in        (upper_cin),
    .result_out      (upper_res),
    .carry_out       (upper_cout),
    .sign_out        (upper_sign)
  );

  mds_acc_half #(
    .W          (OW),
    .FROM_ACC   (LOWER_ADDEND == MDS_ADD_ACC),
    .REGISTERED (ACC_REG)
  ) u_lower (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .cycle_permit_in (cycle_permit_in),
    .freeze_in       (lower_acc_freeze_in),
    .clear_in        (lower_acc_clear_in),
    .preset_sel_in   (lower_acc_preset_sel_in),
    .minus_sel_in    (lower_acc_minus_sel_in),
    .addend_in       (low_q),
    .operand_in      (lower_operand),
    .preset_in       (high_q),
    .carry_in        (lower_cin),
    .result_out      (lower_res),
    .carry_out       (lower_cout),
    .sign_out        (lower_sign)
  );

  // Result output: each half shows either the product or its adder side.
  // Both halves meet in one assignment so the output has a single driver.
  logic [OW-1:0] result_hi;
  logic [OW-1:0] result_lo;

  always_comb begin
    unique case (UPPER_OUT)
      MDS_OUT_PRODUCT: result_hi = product[RW-1:`MDS_HI_LSB];
      MDS_OUT_ADDER:   result_hi = upper_res;
    endcase
  end

  always_comb begin
    unique case (LOWER_OUT)
      MDS_OUT_PRODUCT: result_lo = product[OW-1:0];
      MDS_OUT_ADDER:   result_lo = lower_res;
    endcase
  end

  assign result_out = {result_hi, result_lo};

  // The chain leaves from the top of the whole adder; the fabric tile takes the top carry
  // in a 32-bit add and the lower half's carry otherwise, so a narrow fabric add can extend a 16-bit one.
  assign chain_carry_out = upper_cout;
  assign fabric_carry_out = WIDE_ADD ? upper_cout : lower_cout;
  always_comb begin
    if (SIGN_PASS) begin
      sign_chain_out = sign_chain_in;
    end else if (WIDE_ADD) begin
      sign_chain_out = upper_sign;
    end else begin
      sign_chain_out = lower_sign;
    end
  end
endmodule

// ===== verif/mds_slice_monitor.sv
// Port-level checker of the multiply-accumulate slice.
`timescale 1ns/1ps
module mds_slice_monitor (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        cycle_permit_in,
  input  wire logic [15:0] addend_high_in,
  input  wire logic        addend_high_freeze_in,
  input  wire logic        upper_input_clear_in,
  input  wire logic        lower_input_clear_in,
  input  wire logic        upper_acc_freeze_in,
  input  wire logic        upper_acc_clear_in,
  input  wire logic        upper_acc_preset_sel_in,
  input  wire logic        lower_acc_freeze_in,
  input  wire logic        lower_acc_clear_in,
  input  wire logic        lower_acc_preset_sel_in,
  input  wire logic [31:0] result_out,
  input  wire logic        chain_carry_out,
  input  wire logic        fabric_carry_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic acc_free;
  // With no freeze, clear or load the accumulator adds the product register.
  assign acc_free = cycle_permit_in && !upper_acc_freeze_in && !lower_acc_freeze_in
                    && !upper_acc_clear_in && !lower_acc_clear_in
                    && !upper_acc_preset_sel_in && !lower_acc_preset_sel_in;
  AST_PERMIT_HOLD: assert property (!cycle_permit_in |=> $stable(result_out))
    else $error("result moved while the slice was disabled");
  AST_BOTH_FROZEN: assert property (cycle_permit_in && upper_acc_freeze_in
    && lower_acc_freeze_in && !upper_acc_clear_in && !lower_acc_clear_in |=> $stable(result_out))
    else $error("frozen accumulator changed");
  AST_UPPER_FROZEN: assert property (cycle_permit_in && upper_acc_freeze_in
    && !upper_acc_clear_in |=> $stable(result_out[31:16]))
    else $error("frozen upper half changed");
  AST_UPPER_CLEARED: assert property (cycle_permit_in && upper_acc_clear_in
    |=> result_out[31:16] == 16'h0000) else $error("upper half not cleared");
  AST_LOWER_CLEARED: assert property (cycle_permit_in && lower_acc_clear_in
    |=> result_out[15:0] == 16'h0000) else $error("lower half not cleared");
  AST_PRESET_LOW: assert property (cycle_permit_in && !addend_high_freeze_in
    && !upper_input_clear_in ##1 cycle_permit_in && lower_acc_preset_sel_in
    && !lower_acc_freeze_in && !lower_acc_clear_in
    |=> result_out[15:0] == $past(addend_high_in, 2)) else $error("lower half load wrong");
  AST_LOWER_IN_CLEAR: assert property (cycle_permit_in && lower_input_clear_in
    ##1 acc_free |=> $stable(result_out)) else $error("cleared product was accumulated");
  AST_UPPER_IN_CLEAR: assert property ((cycle_permit_in && upper_input_clear_in)[*3]
    ##1 acc_free |=> $stable(result_out)) else $error("cleared operand reached accumulator");
  AST_CARRY_LINKS: assert property (fabric_carry_out == chain_carry_out)
    else $error("carry links disagree in wide mode");
  cover property (acc_free);
  cover property (upper_acc_preset_sel_in && lower_acc_preset_sel_in);
  cover property (fabric_carry_out);
endmodule

bind mds_slice mds_slice_monitor u_mon (
  .clk_in, .nrst_in, .cycle_permit_in, .addend_high_in, .addend_high_freeze_in,
  .upper_input_clear_in, .lower_input_clear_in, .upper_acc_freeze_in, .upper_acc_clear_in,
  .upper_acc_preset_sel_in, .lower_acc_freeze_in, .lower_acc_clear_in,
  .lower_acc_preset_sel_in, .result_out, .chain_carry_out, .fabric_carry_out
);

// ===== verif/mds_neighbor_model.sv
// Neighbouring slice and fabric tile that feed the carry and sign links and take the fabric carry.
`timescale 1ns/1ps
module mds_neighbor_model (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [2:0] feed_in,
  input  wire logic       carry_seen_in,
  output logic            chain_carry_out,
  output logic            fabric_carry_out,
  output logic            sign_chain_out,
  output logic            carry_taken_out
);
  // Neighbours present their links from registers, as a preceding slice would.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chain_carry_out  <= 1'b0;
      fabric_carry_out <= 1'b0;
      sign_chain_out   <= 1'b0;
      carry_taken_out  <= 1'b0;
    end else begin
      chain_carry_out  <= feed_in[0];
      fabric_carry_out <= feed_in[1];
      sign_chain_out   <= feed_in[2];
      carry_taken_out  <= carry_seen_in;
    end
  end
endmodule

// ===== verif/tb_mds_slice.sv
// Self-checking testbench of the multiply-accumulate slice.
`timescale 1ns/1ps
module tb_mds_slice;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        en = 1'b1;
  logic [15:0] op1 = 16'h0000, op2 = 16'h0000, ahi = 16'h0000, alo = 16'h00A5;
  logic        f1 = 1'b0, f2 = 1'b0, fh = 1'b0, fl = 1'b0, uic = 1'b0, lic = 1'b0;
  logic        uaf = 1'b0, uac = 1'b0, uap = 1'b0, uam = 1'b0;
  logic        laf = 1'b0, lac = 1'b0, lap = 1'b0, lam = 1'b0;
  logic [2:0]  feed = 3'h0;
  logic        cci, fci, sgi, cco, fco, sgo, taken;
  logic [31:0] res;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #2.5 clk_in = ~clk_in;

  mds_slice DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .cycle_permit_in(en),
    .operand_one_in(op1), .operand_two_in(op2),
    .addend_high_in(ahi), .addend_low_in(alo),
    .operand_one_freeze_in(f1), .operand_two_freeze_in(f2),
    .addend_high_freeze_in(fh), .addend_low_freeze_in(fl),
    .upper_input_clear_in(uic), .lower_input_clear_in(lic),
    .upper_acc_freeze_in(uaf), .upper_acc_clear_in(uac),
    .upper_acc_preset_sel_in(uap), .upper_acc_minus_sel_in(uam),
    .lower_acc_freeze_in(laf), .lower_acc_clear_in(lac),
    .lower_acc_preset_sel_in(lap), .lower_acc_minus_sel_in(lam),
    .chain_carry_in(cci), .fabric_carry_in(fci), .sign_chain_in(sgi),
    .result_out(res), .chain_carry_out(cco), .fabric_carry_out(fco), .sign_chain_out(sgo)
  );

  mds_neighbor_model partner (
    .clk_in(clk_in), .nrst_in(nrst_in), .feed_in(feed), .carry_seen_in(fco),
    .chain_carry_out(cci), .fabric_carry_out(fci), .sign_chain_out(sgi),
    .carry_taken_out(taken)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Clears the accumulator while the three-stage pipeline fills, then adds one product.
  task automatic mac_load(input logic [15:0] a, input logic [15:0] b);
    op1 <= a;
    op2 <= b;
    uac <= 1'b1;
    lac <= 1'b1;
    uaf <= 1'b0;
    laf <= 1'b0;
    repeat (4) @(posedge clk_in);
    uac <= 1'b0;
    lac <= 1'b0;
    @(posedge clk_in);
    uaf <= 1'b1;
    laf <= 1'b1;
    @(posedge clk_in);
    #1;
  endtask

  task automatic step(input logic up, input logic lo, input int n);
    uaf <= up;
    laf <= lo;
    repeat (n) @(posedge clk_in);
    uaf <= 1'b1;
    laf <= 1'b1;
    @(posedge clk_in);
    #1;
  endtask

  task automatic preset();
    @(posedge clk_in);
    uap <= 1'b1;
    lap <= 1'b1;
    uaf <= 1'b0;
    laf <= 1'b0;
    @(posedge clk_in);
    uap <= 1'b0;
    lap <= 1'b0;
    uaf <= 1'b1;
    laf <= 1'b1;
    @(posedge clk_in);
    #1;
  endtask

  task automatic t_mult();
    feed <= 3'h5;
    mac_load(16'h00C3, 16'h0A05);
    chk("product", res, 32'h000000C3 * 32'h00000A05);
    mac_load(16'hFFFF, 16'hFFFF);
    chk("full product", res, 32'hFFFE0001);
    chk("fabric carry", {31'h0, fco}, 32'h1);
    chk("chain carry", {31'h0, cco}, 32'h1);
    chk("sign out", {31'h0, sgo}, 32'h1);
    @(posedge clk_in);
    #1;
    chk("carry taken", {31'h0, taken}, 32'h1);
    $display("test mult done");
  endtask

  task automatic t_accum();
    mac_load(16'h0002, 16'h0003);
    step(1'b0, 1'b0, 2);
    chk("accumulate", res, 32'h00000012);
    step(1'b1, 1'b0, 1);
    chk("lower only", res, 32'h00000018);
    uam <= 1'b1;
    lam <= 1'b1;
    step(1'b0, 1'b0, 1);
    chk("subtract", res, 32'h00000012);
    uam <= 1'b0;
    lam <= 1'b0;
    $display("test accum done");
  endtask

  task automatic t_permit();
    en <= 1'b0;
    uac <= 1'b1;
    op1 <= 16'h7777;
    step(1'b0, 1'b0, 3);
    chk("disabled", res, 32'h00000012);
    en <= 1'b1;
    uac <= 1'b0;
    @(posedge clk_in);
    #1;
    $display("test permit done");
  endtask

  task automatic t_opfreeze();
    mac_load(16'h0003, 16'h0005);
    f1 <= 1'b1;
    mac_load(16'h0007, 16'h0005);
    chk("held operand one", res, 32'h0000000F);
    f1 <= 1'b0;
    f2 <= 1'b1;
    mac_load(16'h0007, 16'h0009);
    chk("held operand two", res, 32'h00000023);
    f2 <= 1'b0;
    $display("test operand freeze done");
  endtask

  task automatic t_inclear();
    uic <= 1'b1;
    mac_load(16'h1111, 16'h2222);
    chk("upper input clear", res, 32'h00000000);
    uic <= 1'b0;
    lic <= 1'b1;
    mac_load(16'h1111, 16'h2222);
    chk("lower input clear", res, 32'h00000000);
    lic <= 1'b0;
    $display("test input clear done");
  endtask

  task automatic t_preset();
    ahi <= 16'h1234;
    preset();
    chk("load", res, 32'h12341234);
    fh <= 1'b1;
    ahi <= 16'h5678;
    preset();
    chk("held addend", res, 32'h12341234);
    fh <= 1'b0;
    uic <= 1'b1;
    preset();
    chk("cleared addend", res, 32'h00000000);
    uic <= 1'b0;
    ahi <= 16'h4321;
    preset();
    uac <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("upper clear", res, 32'h00004321);
    uac <= 1'b0;
    lac <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("lower clear", res, 32'h00000000);
    lac <= 1'b0;
    $display("test load done");
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    t_mult();
    t_accum();
    t_permit();
    t_opfreeze();
    t_inclear();
    t_preset();
    end_sim();
  end
endmodule
